// ### hdl/sfwl_host.sv
// host controller for the four-wire link: select handshake, framing, crc
// assumes a single slave; payload bytes are supplied by the user port one per byte slot
`timescale 1ns/10ps
module sfwl_host #(
  parameter int unsigned READY_NS = 2000,
  parameter int unsigned FLOW_LIMIT_CYC = sfwl_pkg::FLOW_MAX_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic power_req_i,
  input wire logic go_i,
  input wire logic [8:0] access_len_i,
  input wire logic [8:0] unit_i,
  input wire logic [7:0] tx_len_i,
  input wire logic tx_has_frame_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_data_req_o,
  output logic [7:0] rx_byte_o,
  output logic rx_valid_o,
  output logic rx_frame_ok_o,
  output logic rx_frame_err_o,
  output logic slave_req_o,
  output logic flow_timeout_o,
  output logic busy_o,
  output logic power_en_o,
  input wire logic sel_i,
  output logic sel_o,
  output logic sel_oe_n_o,
  output logic sck_o,
  output logic mosi_o,
  input wire logic miso_i
);
  import sfwl_pkg::*;
  localparam int unsigned READY_CYC = (READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  sfwl_shift_if sh ();
  sfwl_state_t st_q;
  logic [1:0] sel_sync_q;
  logic [1:0] miso_sync_q;
  logic sel_prev_q;
  logic [15:0] ready_q;
  logic [15:0] flow_q;
  logic [8:0] cnt_q;
  logic [8:0] len_q;
  logic [8:0] tx_idx_q;
  logic [15:0] tx_crc_q;
  logic [15:0] rx_crc_q;
  logic [7:0] rx_len_q;
  logic [8:0] rx_idx_q;
  logic [7:0] rx_hi_q;
  logic rx_live_q;
  logic tx_live_q;
  logic [7:0] tx_len_q;
  logic start_q;
  logic [7:0] tx_byte_q;
  logic [7:0] txb;
  logic sel_low;

  // ============================================================
  // synchronisers for pins from the slave side
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_sync_q <= 2'b11;
      miso_sync_q <= 2'b11;
      sel_prev_q <= 1'b1;
    end else begin
      sel_sync_q <= {sel_sync_q[0], sel_i};
      miso_sync_q <= {miso_sync_q[0], miso_i};
      sel_prev_q <= sel_sync_q[1];
    end
  end
  assign sel_low = !sel_sync_q[1];

  // ============================================================
  // transmit byte selection: length, payload, crc, then idle fill
  always_comb begin
    txb = IDLE_BYTE;
    if (tx_live_q) begin
      if (tx_idx_q == 9'h000) begin
        txb = tx_len_q;
      end else if (tx_idx_q <= {1'b0, tx_len_q}) begin
        txb = tx_data_i;
      end else if (tx_idx_q == {1'b0, tx_len_q} + 9'h001) begin
        txb = tx_crc_q[15:8];
      end else if (tx_idx_q == {1'b0, tx_len_q} + 9'h002) begin
        txb = tx_crc_q[7:0];
      end
    end
  end

  // ============================================================
  // access sequencer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= SFWL_OFF;
      sel_o <= 1'b1;
      sel_oe_n_o <= 1'b1;
      power_en_o <= 1'b0;
      busy_o <= 1'b0;
      ready_q <= 16'h0000;
      cnt_q <= 9'h000;
      len_q <= 9'h000;
      tx_idx_q <= 9'h000;
      tx_crc_q <= CRC_PRESET;
      tx_live_q <= 1'b0;
      tx_len_q <= 8'h00;
      start_q <= 1'b0;
      tx_byte_q <= IDLE_BYTE;
      tx_data_req_o <= 1'b0;
    end else begin
      start_q <= 1'b0;
      tx_data_req_o <= 1'b0;
      unique case (st_q)
        SFWL_OFF: begin
          sel_oe_n_o <= 1'b1;
          if (power_req_i) begin
            power_en_o <= 1'b1;
            st_q <= SFWL_IDLE;
          end
        end
        SFWL_IDLE: begin
          busy_o <= 1'b0;
          if (!power_req_i) begin
            sel_oe_n_o <= 1'b1;
            power_en_o <= 1'b0;
            st_q <= SFWL_OFF;
          end else if (go_i && !sel_low && access_len_i != 9'h000
                       && access_len_i <= unit_i) begin
            sel_o <= 1'b0;
            sel_oe_n_o <= 1'b0;
            busy_o <= 1'b1;
            len_q <= access_len_i;
            tx_len_q <= tx_len_i;
            // reserved or oversize lengths are sent as idle fill only
            tx_live_q <= tx_has_frame_i && tx_len_i != LEN_RESERVED_LO
                         && tx_len_i != LEN_RESERVED_HI && tx_len_i != LEN_NO_FRAME
                         && tx_len_i <= sfwl_max_len(unit_i)
                         && ({1'b0, tx_len_i} + FRAME_OVERHEAD) <= access_len_i;
            ready_q <= 16'h0000;
            // cleared here, because READY picks the first byte from these before it leaves
            tx_idx_q <= 9'h000;
            cnt_q <= 9'h000;
            tx_crc_q <= CRC_PRESET;
            st_q <= SFWL_READY;
          end
        end
        SFWL_READY: begin
          // also covers a slave request racing ours: the slave sees a host access
          ready_q <= ready_q + 16'h0001;
          if (ready_q >= 16'(READY_CYC)) begin
            tx_idx_q <= 9'h000;
            cnt_q <= 9'h000;
            tx_crc_q <= CRC_PRESET;
            st_q <= SFWL_XFER;
            start_q <= 1'b1;
            tx_byte_q <= txb;
          end
        end
        SFWL_XFER: begin
          if (sh.done) begin
            // only length and payload feed the trailer; the trailer bytes must not
            if (tx_idx_q <= {1'b0, tx_len_q}) begin
              tx_crc_q <= sfwl_crc_byte(tx_crc_q, tx_byte_q);
            end
            tx_idx_q <= tx_idx_q + 9'h001;
            cnt_q <= cnt_q + 9'h001;
            if (tx_idx_q < {1'b0, tx_len_q} && tx_live_q) begin
              tx_data_req_o <= 1'b1;
            end
            if (cnt_q + 9'h001 == len_q) begin
              ready_q <= 16'h0000;
              st_q <= SFWL_END;
            end
          end else if (!start_q && cnt_q != 9'h000 && ready_q == 16'h0000) begin
            start_q <= 1'b1;
            tx_byte_q <= txb;
            ready_q <= 16'h0001;
          end else if (start_q) begin
            ready_q <= 16'h0001;
          end
          if (sh.done) begin
            ready_q <= 16'h0000;
          end
        end
        SFWL_END: begin
          ready_q <= ready_q + 16'h0001;
          if (ready_q == 16'(CS_GAP_CYC)) begin
            sel_o <= 1'b1;
            sel_oe_n_o <= 1'b1;
            st_q <= SFWL_HOLD;
          end
        end
        SFWL_HOLD: begin
          // slave may still hold select low for flow control
          if (!sel_low) begin
            st_q <= SFWL_IDLE;
          end
        end
        default: st_q <= SFWL_OFF;
      endcase
    end
  end
  assign sh.start = start_q;
  assign sh.tx_byte = tx_byte_q;

  // ============================================================
  // flow-control watchdog and slave request detection
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flow_q <= 16'h0000;
      flow_timeout_o <= 1'b0;
      slave_req_o <= 1'b0;
    end else begin
      slave_req_o <= (st_q == SFWL_IDLE) && sel_prev_q && sel_low;
      if (st_q == SFWL_HOLD && sel_low) begin
        if (flow_q != 16'(FLOW_LIMIT_CYC)) begin
          flow_q <= flow_q + 16'h0001;
        end
        flow_timeout_o <= flow_q == 16'(FLOW_LIMIT_CYC);
      end else begin
        flow_q <= 16'h0000;
        flow_timeout_o <= 1'b0;
      end
    end
  end

  // ============================================================
  // receive framing and crc check
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_crc_q <= CRC_PRESET;
      rx_len_q <= 8'h00;
      rx_idx_q <= 9'h000;
      rx_hi_q <= 8'h00;
      rx_live_q <= 1'b0;
      rx_byte_o <= 8'h00;
      rx_valid_o <= 1'b0;
      rx_frame_ok_o <= 1'b0;
      rx_frame_err_o <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      rx_frame_ok_o <= 1'b0;
      rx_frame_err_o <= 1'b0;
      if (st_q == SFWL_READY) begin
        rx_idx_q <= 9'h000;
        rx_crc_q <= CRC_PRESET;
        rx_live_q <= 1'b0;
      end else if (st_q == SFWL_XFER && sh.done) begin
        rx_idx_q <= rx_idx_q + 9'h001;
        if (rx_idx_q == 9'h000) begin
          rx_len_q <= sh.rx_byte;
          rx_crc_q <= sfwl_crc_byte(CRC_PRESET, sh.rx_byte);
          rx_live_q <= sh.rx_byte != LEN_NO_FRAME && sh.rx_byte != LEN_RESERVED_LO
                       && sh.rx_byte != LEN_RESERVED_HI;
        end else if (rx_live_q) begin
          if (rx_idx_q <= {1'b0, rx_len_q}) begin
            rx_crc_q <= sfwl_crc_byte(rx_crc_q, sh.rx_byte);
            rx_byte_o <= sh.rx_byte;
            rx_valid_o <= 1'b1;
          end else if (rx_idx_q == {1'b0, rx_len_q} + 9'h001) begin
            rx_hi_q <= sh.rx_byte;
          end else if (rx_idx_q == {1'b0, rx_len_q} + 9'h002) begin
            rx_live_q <= 1'b0;
            rx_frame_ok_o <= {rx_hi_q, sh.rx_byte} == rx_crc_q;
            rx_frame_err_o <= {rx_hi_q, sh.rx_byte} != rx_crc_q;
          end
        end
      end
    end
  end

  sfwl_shifter u_shift (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .sh(sh),
    .miso_i(miso_sync_q[1]),
    .sck_o(sck_o),
    .mosi_o(mosi_o)
  );
endmodule // sfwl_host

// ### hdl/sfwl_pkg.sv
// constants shared by the four-wire link host controller and its byte shifter
// assumes a 100 MHz system clock and one slave on the shared select line
package sfwl_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PULSE_MIN_US = 1;
  localparam int unsigned FLOW_MAX_US = 500;
  localparam int unsigned FLOW_MAX_CYC = (FLOW_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned SCK_HALF_CYC = 4;
  localparam int unsigned CS_GAP_CYC = 10;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic [7:0] LEN_RESERVED_LO = 8'h00;
  localparam logic [7:0] LEN_RESERVED_HI = 8'hFE;
  localparam logic [7:0] LEN_NO_FRAME = 8'hFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [8:0] FRAME_OVERHEAD = 9'h003;

  typedef enum logic [2:0] {
    SFWL_OFF = 3'b000,
    SFWL_IDLE = 3'b001,
    SFWL_READY = 3'b010,
    SFWL_XFER = 3'b011,
    SFWL_END = 3'b100,
    SFWL_HOLD = 3'b101
  } sfwl_state_t;

  // crc-16 step over one byte, msb first
  function automatic logic [15:0] sfwl_crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ b[i]) begin
        c = {c[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  // largest legal payload length for a transfer unit of n bytes
  function automatic logic [7:0] sfwl_max_len(input logic [8:0] unit);
    logic [8:0] m;
    m = unit - FRAME_OVERHEAD;
    return m[7:0];
  endfunction
endpackage

// ### hdl/sfwl_shift_if.sv
// byte handshake between the host sequencer and the bit shifter
// assumes both ends share one clock
`timescale 1ns/10ps
interface sfwl_shift_if;
  logic start;
  logic [7:0] tx_byte;
  logic done;
  logic [7:0] rx_byte;
  modport ctl (output start, output tx_byte, input done, input rx_byte);
  modport shf (input start, input tx_byte, output done, output rx_byte);
endinterface

// ### hdl/sfwl_shifter.sv
// mode-0 byte shifter: one byte per start pulse, msb first
// assumes miso already passed a two-stage synchroniser
`timescale 1ns/10ps
module sfwl_shifter (
  input wire logic clk_i,
  input wire logic rst_n_i,
  sfwl_shift_if.shf sh,
  input wire logic miso_i,
  output logic sck_o,
  output logic mosi_o
);
  import sfwl_pkg::*;
  logic [7:0] sr_q;
  logic [7:0] rx_q;
  logic [2:0] bit_q;
  logic [3:0] div_q;
  logic busy_q;
  logic done_q;

  // ============================================================
  // shift engine
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sr_q <= 8'hFF;
      rx_q <= 8'h00;
      bit_q <= 3'h0;
      div_q <= 4'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      sck_o <= 1'b0;
      mosi_o <= 1'b1;
    end else begin
      done_q <= 1'b0;
      if (!busy_q) begin
        if (sh.start) begin
          busy_q <= 1'b1;
          sr_q <= {sh.tx_byte[6:0], 1'b1};
          mosi_o <= sh.tx_byte[7];
          bit_q <= 3'h0;
          div_q <= 4'h0;
        end
      end else if (div_q == 4'(SCK_HALF_CYC - 1)) begin
        div_q <= 4'h0;
        if (!sck_o) begin
          sck_o <= 1'b1;
          rx_q <= {rx_q[6:0], miso_i};
        end else begin
          sck_o <= 1'b0;
          if (bit_q == 3'h7) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            // data line idles high once the last bit has been taken
            mosi_o <= 1'b1;
          end else begin
            mosi_o <= sr_q[7];
            sr_q <= {sr_q[6:0], 1'b1};
            bit_q <= bit_q + 3'h1;
          end
        end
      end else begin
        div_q <= div_q + 4'h1;
      end
    end
  end

  assign sh.done = done_q;
  assign sh.rx_byte = rx_q;
endmodule // sfwl_shifter

// ### sim/sfwl_host_properties.sv
// port-level assertions for the link host controller
// assumes one clock domain; bound to every host instance
`timescale 1ns/10ps
module sfwl_host_properties #(
  parameter int unsigned READY_NS = 2000,
  parameter int unsigned FLOW_LIMIT_CYC = sfwl_pkg::FLOW_MAX_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic power_req_i,
  input wire logic go_i,
  input wire logic [8:0] access_len_i,
  input wire logic [8:0] unit_i,
  input wire logic [7:0] tx_len_i,
  input wire logic tx_has_frame_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_data_req_o,
  input wire logic [7:0] rx_byte_o,
  input wire logic rx_valid_o,
  input wire logic rx_frame_ok_o,
  input wire logic rx_frame_err_o,
  input wire logic slave_req_o,
  input wire logic flow_timeout_o,
  input wire logic busy_o,
  input wire logic power_en_o,
  input wire logic sel_i,
  input wire logic sel_o,
  input wire logic sel_oe_n_o,
  input wire logic sck_o,
  input wire logic mosi_o,
  input wire logic miso_i
);
  localparam int unsigned RDY = READY_NS / 10;
  logic [15:0] cnt_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // =====
  // cycles since select was asserted, saturating
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 16'h0000;
    end else if (sel_oe_n_o) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q != 16'hFFFF) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  // =====
  // properties
  a_ready_before_clock: assert property ($rose(sck_o) |-> cnt_q >= RDY)
    else $error("clock before ready time");
  a_clock_in_select: assert property (sck_o |-> !sel_oe_n_o && !sel_o)
    else $error("clock outside select");
  a_sck_high_four: assert property ($rose(sck_o) |-> sck_o [*4] ##1 !sck_o)
    else $error("clock high phase wrong");
  a_release_after_stop: assert property ($rose(sel_o | sel_oe_n_o) |-> !$past(sck_o, 9))
    else $error("select released too soon");
  a_power_sel_off: assert property (!power_en_o |-> sel_oe_n_o)
    else $error("select driven while unpowered");
  a_idle_mosi_high: assert property (sel_oe_n_o |-> mosi_o)
    else $error("mosi not idle");
  a_flow_timeout_low: assert property ($rose(flow_timeout_o) |-> !sel_i && !$past(sel_i, 8))
    else $error("timeout without held select");
  a_frame_flags_excl: assert property (!(rx_frame_ok_o && rx_frame_err_o))
    else $error("both frame flags");
  a_rx_in_access: assert property (rx_valid_o |-> busy_o)
    else $error("payload outside access");
  c_slave_req: cover property (slave_req_o);
  c_frame_err: cover property (rx_frame_err_o);
  c_flow_timeout: cover property ($rose(flow_timeout_o));
endmodule // sfwl_host_properties

bind sfwl_host sfwl_host_properties #(
  .READY_NS(READY_NS),
  .FLOW_LIMIT_CYC(FLOW_LIMIT_CYC)
) u_sfwl_host_properties (.*);

// ### sim/sfwl_slave_model.sv
// behavioural slave on the far side of the four-wire link
// assumes an open-drain select net and pull-ups on the select and miso nets in the bench
`timescale 1ns/10ps
module sfwl_slave_model (
  input wire logic clk_i,
  input wire logic pwr_i,
  input wire logic req_i,
  input wire logic hold_i,
  input wire logic bad_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  inout wire sel_io,
  output wire miso_o
);
  logic low_q = 1'b0;
  logic en_q = 1'b1;
  int n = 0;
  int bi = 0;
  logic [7:0] sr;
  logic [7:0] rx_q[$];
  logic [7:0] fr[6];
  logic [15:0] c;
  function automatic logic [15:0] crc(input logic [15:0] v, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) v = {v[14:0], 1'b0} ^ ((v[15] ^ b[i]) ? 16'h1021 : 16'h0000);
    return v;
  endfunction
  // =====
  // frame
  initial begin
    fr = '{8'h03, 8'hC0, 8'h11, 8'h22, 8'h00, 8'h00};
    c = 16'hFFFF;
    for (int i = 0; i < 4; i++) c = crc(c, fr[i]);
    fr[4] = c[15:8];
    fr[5] = c[7:0];
  end
  // =====
  // select handshake
  // unpowered: nothing driven
  assign sel_io = (pwr_i && low_q) ? 1'b0 : 1'bz;
  wire act = pwr_i && en_q && (sel_io === 1'b0);
  always @(posedge clk_i) begin
    if (req_i && en_q && sel_io === 1'b1) begin
      en_q <= 1'b0;
      low_q <= 1'b1;
      n <= 0;
    end else if (!en_q) begin
      n <= n + 1;
      // 150 cycles covers the 1 us pulse yet ends before the host ready wait
      if (n == 150) begin
        low_q <= 1'b0;
        en_q <= 1'b1;
      end
    end else begin
      low_q <= hold_i;
    end
  end
  // =====
  // shifting
  always @(posedge clk_i) if (sel_io === 1'b1) bi = 0;
  always @(negedge sck_i) if (act) bi++;
  always @(posedge sck_i) begin
    if (act) begin
      sr = {sr[6:0], mosi_i};
      if (bi % 8 == 7) rx_q.push_back(sr);
    end
  end
  // a corrupted trailer only when the bench asks for it
  wire [7:0] cur = (bi < 40) ? fr[bi/8] : (bi < 48) ? fr[5] ^ {7'h00, bad_i} : 8'hFF;
  assign miso_o = act ? cur[7 - bi % 8] : 1'bz;
endmodule // sfwl_slave_model

// ### sim/tb_spi_four_wire_mac_link_frame.sv
// self-checking bench for the link host against the slave model
// assumes the checker is bound from its own file
`timescale 1ns/10ps
module tb_spi_four_wire_mac_link_frame;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic power_req_i = 1'b0;
  logic go_i = 1'b0;
  logic req_q = 1'b0;
  logic hold_q = 1'b0;
  logic bad_q = 1'b0;
  logic tx_has_frame_i = 1'b0;
  logic [8:0] access_len_i = 9'h008;
  logic [8:0] unit_i = 9'h020;
  logic [7:0] tx_len_i = 8'h02;
  logic [7:0] idx_q = 8'h00;
  logic [7:0] rxq[$];
  int ok_n, err_n, fail_count, checks_done, t;
  wire tx_data_req_o, rx_valid_o, rx_frame_ok_o, rx_frame_err_o, slave_req_o;
  wire flow_timeout_o, busy_o, power_en_o, sel_o, sel_oe_n_o, sck_o, mosi_o;
  wire [7:0] rx_byte_o;
  tri1 sel_w;
  tri1 miso_w;
  assign sel_w = (!sel_oe_n_o && !sel_o) ? 1'b0 : 1'bz;
  sfwl_host #(.READY_NS(2000), .FLOW_LIMIT_CYC(50)) u_sfwl_host (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .power_req_i(power_req_i), .go_i(go_i),
    .access_len_i(access_len_i), .unit_i(unit_i), .tx_len_i(tx_len_i),
    .tx_has_frame_i(tx_has_frame_i), .tx_data_i(8'hA0 + idx_q),
    .tx_data_req_o(tx_data_req_o), .rx_byte_o(rx_byte_o), .rx_valid_o(rx_valid_o),
    .rx_frame_ok_o(rx_frame_ok_o), .rx_frame_err_o(rx_frame_err_o),
    .slave_req_o(slave_req_o), .flow_timeout_o(flow_timeout_o), .busy_o(busy_o),
    .power_en_o(power_en_o), .sel_i(sel_w), .sel_o(sel_o), .sel_oe_n_o(sel_oe_n_o),
    .sck_o(sck_o), .mosi_o(mosi_o), .miso_i(miso_w));
  sfwl_slave_model u_sfwl_slave_model (.clk_i(clk_i), .pwr_i(power_en_o), .req_i(req_q),
    .hold_i(hold_q), .bad_i(bad_q), .sck_i(sck_o), .mosi_i(mosi_o), .sel_io(sel_w),
    .miso_o(miso_w));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (busy_o !== 1'b1) idx_q <= 8'h00;
    else if (tx_data_req_o === 1'b1) idx_q <= idx_q + 8'h01;
    if (rx_valid_o === 1'b1) rxq.push_back(rx_byte_o);
    if (rx_frame_ok_o === 1'b1) ok_n++;
    if (rx_frame_err_o === 1'b1) err_n++;
  end
  // =====
  // helpers
  task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_f(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [8:0] len, input logic [7:0] tl, input logic hf, input logic hl);
    rxq.delete();
    u_sfwl_slave_model.rx_q.delete();
    ok_n = 0;
    err_n = 0;
    access_len_i <= len;
    tx_len_i <= tl;
    tx_has_frame_i <= hf;
    go_i <= 1'b1;
    @(posedge clk_i);
    go_i <= 1'b0;
    req_q <= 1'b0;
    repeat (3) @(posedge clk_i);
    hold_q <= hl;
    // an access ends when the host lets go of select; under flow control it stays busy
    for (t = 0; t < 5000 && sel_oe_n_o !== 1'b1; t++) @(posedge clk_i);
    while (t < 5000 && !hl && busy_o === 1'b1) begin
      @(posedge clk_i);
      t++;
    end
    chk_f(t < 5000, 1'b1);
    repeat (2) @(posedge clk_i);
  endtask
  // fl is the host payload length, 0 when only fill is expected
  task automatic chk_mosi(input int len, input int fl);
    logic [15:0] c;
    logic [7:0] e;
    c = 16'hFFFF;
    chk_b(8'(u_sfwl_slave_model.rx_q.size()), 8'(len));
    for (int k = 0; k < len; k++) begin
      if (fl == 0 || k > fl + 2) e = 8'hFF;
      else if (k == 0) e = 8'(fl);
      else if (k <= fl) e = 8'(8'hA0 + k - 1);
      else e = (k == fl + 1) ? c[15:8] : c[7:0];
      if (fl != 0 && k <= fl) c = u_sfwl_slave_model.crc(c, e);
      chk_b(u_sfwl_slave_model.rx_q[k], e);
    end
  endtask
  task automatic chk_slave(input logic good);
    chk_f(ok_n == 1, good);
    chk_f(err_n == 1, !good);
    for (int k = 0; k < 3 && good; k++) chk_b(rxq[k], u_sfwl_slave_model.fr[k + 1]);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // =====
  // scenarios
  task automatic t_power;
    chk_f(power_en_o, 1'b0);
    chk_f(sel_oe_n_o, 1'b1);
    power_req_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk_f(power_en_o, 1'b1);
    $display("power done");
  endtask
  task automatic t_host_frame;
    run(9'h008, 8'h02, 1'b1, 1'b0);
    chk_mosi(8, 2);
    chk_slave(1'b1);
    $display("host frame done");
  endtask
  task automatic t_slave_req;
    req_q <= 1'b1;
    @(posedge clk_i);
    req_q <= 1'b0;
    for (t = 0; t < 20 && slave_req_o !== 1'b1; t++) @(posedge clk_i);
    chk_f(slave_req_o, 1'b1);
    repeat (80) @(posedge clk_i);
    chk_f(sel_w, 1'b0);
    for (t = 0; t < 300 && sel_w !== 1'b1; t++) @(posedge clk_i);
    chk_f(sel_w, 1'b1);
    repeat (3) @(posedge clk_i);
    run(9'h006, 8'h02, 1'b0, 1'b0);
    chk_mosi(6, 0);
    chk_slave(1'b1);
    $display("slave request done");
  endtask
  task automatic t_simul;
    req_q <= 1'b1;
    run(9'h008, 8'h02, 1'b1, 1'b0);
    chk_mosi(8, 2);
    chk_slave(1'b1);
    $display("simultaneous done");
  endtask
  task automatic t_crc_err;
    bad_q <= 1'b1;
    run(9'h008, 8'h02, 1'b0, 1'b0);
    chk_slave(1'b0);
    bad_q <= 1'b0;
    $display("crc error done");
  endtask
  task automatic t_refuse;
    run(9'h000, 8'h02, 1'b1, 1'b0);
    chk_mosi(0, 0);
    run(9'h021, 8'h02, 1'b1, 1'b0);
    chk_mosi(0, 0);
    run(9'h008, 8'hFE, 1'b1, 1'b0);
    chk_mosi(8, 0);
    run(9'h008, 8'h00, 1'b1, 1'b0);
    chk_mosi(8, 0);
    $display("refusals done");
  endtask
  task automatic t_flow;
    run(9'h008, 8'h02, 1'b1, 1'b1);
    chk_mosi(8, 2);
    chk_slave(1'b1);
    chk_f(flow_timeout_o, 1'b0);
    run(9'h008, 8'h02, 1'b1, 1'b1);
    chk_mosi(0, 0);
    for (t = 0; t < 200 && flow_timeout_o !== 1'b1; t++) @(posedge clk_i);
    chk_f(flow_timeout_o, 1'b1);
    hold_q <= 1'b0;
    for (t = 0; t < 50 && busy_o === 1'b1; t++) @(posedge clk_i);
    chk_f(busy_o, 1'b0);
    chk_f(flow_timeout_o, 1'b0);
    $display("flow control done");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_power;
    t_host_frame;
    t_slave_req;
    t_simul;
    t_crc_err;
    t_refuse;
    t_flow;
    stop_test;
  end
  // about ten accesses of under a thousand cycles each
  initial begin
    #400000;
    fail_count++;
    stop_test;
  end
endmodule // tb_spi_four_wire_mac_link_frame
